// ===== design/gtc_pkg.sv
// Purpose: constants shared by the gated 16-bit timer/counter design
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   every offset, field position and multi-bit reset value lives here
package gtc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] GTC_ADDR_INTERRUPT_CONTROL     = 8'h0b;
    localparam logic [7:0] GTC_ADDR_PERIPHERAL_FLAGS      = 8'h0c;
    localparam logic [7:0] GTC_ADDR_COUNT_LOW_BYTE        = 8'h0e;
    localparam logic [7:0] GTC_ADDR_COUNT_HIGH_BYTE       = 8'h0f;
    localparam logic [7:0] GTC_ADDR_TIMER_CONTROL         = 8'h10;
    localparam logic [7:0] GTC_ADDR_PERIPHERAL_INT_ENABLE = 8'h8c;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int GTC_BIT_GLOBAL_INT_ENABLE     = 7;
    localparam int GTC_BIT_PERIPH_INT_ENABLE_BIT = 6;
    localparam int GTC_BIT_OVERFLOW_FLAG         = 0;
    localparam int GTC_BIT_OVERFLOW_INT_ENABLE   = 0;
    localparam int GTC_BIT_GATE_ENABLE           = 6;
    localparam int GTC_BIT_PRESCALE_SEL_HI       = 5;
    localparam int GTC_BIT_PRESCALE_SEL_LO       = 4;
    localparam int GTC_BIT_LP_OSC_ENABLE         = 3;
    localparam int GTC_BIT_SYNC_BYPASS           = 2;
    localparam int GTC_BIT_CLOCK_SOURCE_SELECT   = 1;
    localparam int GTC_BIT_TIMER_ON              = 0;

    // ------------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------------
    localparam logic [7:0]  GTC_RST_BYTE        = 8'h00;
    localparam logic [6:0]  GTC_RST_CONTROL     = 7'h00;
    localparam logic [15:0] GTC_RST_COUNT       = 16'h0000;
    localparam logic [15:0] GTC_COUNT_MAX       = 16'hffff;
    localparam logic [15:0] GTC_COUNT_ONE       = 16'h0001;
    localparam logic [1:0]  GTC_PORT_PIN_FORCED = 2'h0;
    localparam logic [1:0]  GTC_PORT_DIR_FORCED = 2'h3;

    // ------------------------------------------------------------------
    // prescaler: terminal counts for 1:1, 1:2, 1:4, 1:8
    // ------------------------------------------------------------------
    localparam logic [2:0] GTC_PRE_ZERO    = 3'h0;
    localparam logic [2:0] GTC_PRE_ONE     = 3'h1;
    localparam logic [2:0] GTC_PRE_TERM_1  = 3'h0;
    localparam logic [2:0] GTC_PRE_TERM_2  = 3'h1;
    localparam logic [2:0] GTC_PRE_TERM_4  = 3'h3;
    localparam logic [2:0] GTC_PRE_TERM_8  = 3'h7;

    // instruction clock is the system clock divided by four
    localparam logic [1:0] GTC_INSTR_LAST  = 2'h3;
    localparam logic [1:0] GTC_INSTR_ONE   = 2'h1;
    localparam logic [1:0] GTC_INSTR_ZERO  = 2'h0;

endpackage

// ===== design/gtc_timer.sv
// Purpose: gated 16-bit timer/counter with 1/2/4/8 prescaler
// Assumes: all pins except the count clock sources synchronous to clk_sys_i; byte-wide register port
// Notes:   the unsynchronised path samples the pin once and keeps
//          counting while sleep_i is high; the internal clock halts
// Overview of operation
// - count is a 16-bit pair of bytes wrapping all-ones to zero.
// - every wrap sets overflow flag, bit 0 of peripheral flags.
// - interrupt request only when flag, timer enable, peripheral, global set.
// - overflow flag stays set until software writes it to zero.
// - source select bit 1 picks external rising edges or system clock/4.
// - counter mode needs a falling edge before the first counted rise.
// - gate bit 6: when on, 1 counts only while gate pin is low.
// - prescale bits 5-4 divide by 8, 4, 2 or 1.
// - prescaler hidden; a write to either count byte clears it.
// - oscillator enable bit 3 acts only with internal osc, no clock out.
// - bit 2 bypasses external sync when 1; ignored for internal source.
// - on bit 0 enables counting; 0 stops with count kept.
// - unsynchronised counter mode keeps counting in sleep and can wake.
// - count byte reads are never corrupted while counting externally.
// - with oscillator on, its two pins read 0 and directions read 1.
// - in sleep only async counts; wake needs on, enable, peripheral bits.
// - timer mode advances once per instruction cycle, via prescaler.
`timescale 1ns/1ps

module gtc_timer
    import gtc_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       srst_i,
    // register port
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // clock sources and gate
    input  wire logic       ext_clock_pin_i,
    input  wire logic       lp_osc_clk_i,
    input  wire logic       gate_pin_n_i,
    // system state
    input  wire logic       sleep_i,
    input  wire logic       internal_oscillator_i,
    // shared port pins
    input  wire logic [1:0] port_pin_i,
    input  wire logic [1:0] port_dir_i,
    output logic      [1:0] port_pin_view_o,
    output logic      [1:0] port_dir_view_o,
    output logic            lp_osc_run_o,
    // requests to the core
    output logic            irq_o,
    output logic            wake_o
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic        global_int_enable_q;
    logic        peripheral_int_enable_bit_q;
    logic        overflow_flag_q;
    logic        overflow_int_enable_q;
    logic [6:0]  timer_control_q;
    logic [15:0] count_q;
    logic [15:0] count_d;

    // control fields
    logic        gate_enable;
    logic [1:0]  prescale_sel;
    logic        lp_osc_enable;
    logic        sync_bypass;
    logic        clock_source_select;
    logic        timer_on;

    assign gate_enable         = timer_control_q[GTC_BIT_GATE_ENABLE];
    assign prescale_sel        = {timer_control_q[GTC_BIT_PRESCALE_SEL_HI],
                                  timer_control_q[GTC_BIT_PRESCALE_SEL_LO]};
    assign lp_osc_enable       = timer_control_q[GTC_BIT_LP_OSC_ENABLE];
    assign sync_bypass         = timer_control_q[GTC_BIT_SYNC_BYPASS];
    assign clock_source_select = timer_control_q[GTC_BIT_CLOCK_SOURCE_SELECT];
    assign timer_on            = timer_control_q[GTC_BIT_TIMER_ON];

    // ------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------
    logic wr_interrupt_control;
    logic wr_flags;
    logic wr_low;
    logic wr_high;
    logic wr_ctrl;
    logic wr_pie;

    assign wr_interrupt_control = reg_wr_i && (reg_addr_i == GTC_ADDR_INTERRUPT_CONTROL);
    assign wr_flags  = reg_wr_i && (reg_addr_i == GTC_ADDR_PERIPHERAL_FLAGS);
    assign wr_low    = reg_wr_i && (reg_addr_i == GTC_ADDR_COUNT_LOW_BYTE);
    assign wr_high   = reg_wr_i && (reg_addr_i == GTC_ADDR_COUNT_HIGH_BYTE);
    assign wr_ctrl   = reg_wr_i && (reg_addr_i == GTC_ADDR_TIMER_CONTROL);
    assign wr_pie    = reg_wr_i
                       && (reg_addr_i == GTC_ADDR_PERIPHERAL_INT_ENABLE);

    // ------------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------------
    // oscillator only takes over with internal osc and no clock output
    logic lp_osc_active;
    logic ext_source;

    assign lp_osc_active = lp_osc_enable && internal_oscillator_i;
    assign ext_source    = lp_osc_active ? lp_osc_clk_i : ext_clock_pin_i;

    // instruction clock: one tick every fourth system clock, halted
    // in sleep because the core clock stops there
    logic [1:0] instr_div_q;
    logic       instr_tick;

    assign instr_tick = (instr_div_q == GTC_INSTR_LAST) && !sleep_i;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            instr_div_q <= GTC_INSTR_ZERO;
        else if (!sleep_i)
            instr_div_q <= instr_div_q + GTC_INSTR_ONE;
    end

    // two-stage synchroniser plus history stage for edge detection;
    // the second stage and the history stage feed the edge logic
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic sync_rise;
    logic sync_fall;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= ext_source;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign sync_rise = sync2_q && !sync3_q;
    assign sync_fall = !sync2_q && sync3_q;

    // unsynchronised path: single sample, no synchroniser latency,
    // and it is not gated by sleep so it keeps counting
    logic pin_now_q;
    logic pin_prev_q;
    logic async_rise;
    logic async_fall;

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            pin_now_q  <= 1'b0;
            pin_prev_q <= 1'b0;
        end
        else
        begin
            pin_now_q  <= ext_source;
            pin_prev_q <= pin_now_q;
        end
    end

    assign async_rise = pin_now_q && !pin_prev_q;
    assign async_fall = !pin_now_q && pin_prev_q;

    // ------------------------------------------------------------------
    // falling edge arming for counter mode
    // ------------------------------------------------------------------
    // a pin that idles high at enable must not give a spurious count
    logic armed_q;
    logic ext_fall;
    logic ext_rise;

    assign ext_fall = sync_bypass ? async_fall : sync_fall;
    assign ext_rise = sync_bypass ? async_rise
                                  : (sync_rise && !sleep_i);

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            armed_q <= 1'b0;
        else if (!clock_source_select || !timer_on)
            armed_q <= 1'b0;
        else if (ext_fall)
            armed_q <= 1'b1;
    end

    // ------------------------------------------------------------------
    // qualified source edge, gate and prescaler
    // ------------------------------------------------------------------
    logic src_edge;
    logic count_allowed;
    logic [2:0] pre_q;
    logic [2:0] pre_term;
    logic pre_pulse;

    // internal source ignores the bypass bit entirely
    assign src_edge = clock_source_select ? (ext_rise && armed_q)
                                          : instr_tick;

    // gate bit only matters while the timer is on
    assign count_allowed = timer_on
                           && (!gate_enable || !gate_pin_n_i);

    always_comb
    begin
        unique case (prescale_sel)
            2'h0:    pre_term = GTC_PRE_TERM_1;
            2'h1:    pre_term = GTC_PRE_TERM_2;
            2'h2:    pre_term = GTC_PRE_TERM_4;
            2'h3:    pre_term = GTC_PRE_TERM_8;
        endcase
    end

    assign pre_pulse = src_edge && count_allowed && (pre_q == pre_term);

    // prescaler is not software visible; a count byte write clears it
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            pre_q <= GTC_PRE_ZERO;
        else if (wr_low || wr_high)
            pre_q <= GTC_PRE_ZERO;
        else if (src_edge && count_allowed)
            pre_q <= (pre_q == pre_term) ? GTC_PRE_ZERO
                                         : pre_q + GTC_PRE_ONE;
    end

    // ------------------------------------------------------------------
    // 16-bit count
    // ------------------------------------------------------------------
    logic wrap;

    assign wrap = pre_pulse && (count_q == GTC_COUNT_MAX);

    // a colliding write wins over the increment; software is expected
    // to stop the timer first so this is only a defined tie-break
    always_comb
    begin
        count_d = count_q;
        if (pre_pulse)
            count_d = count_q + GTC_COUNT_ONE;
        if (wr_low)
            count_d[7:0] = reg_wdata_i;
        if (wr_high)
            count_d[15:8] = reg_wdata_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            count_q <= GTC_RST_COUNT;
        else
            count_q <= count_d;
    end

    // ------------------------------------------------------------------
    // control and enable registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            timer_control_q <= GTC_RST_CONTROL;
        else if (wr_ctrl)
            timer_control_q <= reg_wdata_i[6:0];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            global_int_enable_q         <= 1'b0;
            peripheral_int_enable_bit_q <= 1'b0;
        end
        else if (wr_interrupt_control)
        begin
            global_int_enable_q <= reg_wdata_i[GTC_BIT_GLOBAL_INT_ENABLE];
            peripheral_int_enable_bit_q <=
                reg_wdata_i[GTC_BIT_PERIPH_INT_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            overflow_int_enable_q <= 1'b0;
        else if (wr_pie)
            overflow_int_enable_q <= reg_wdata_i[GTC_BIT_OVERFLOW_INT_ENABLE];
    end

    // ------------------------------------------------------------------
    // overflow flag
    // ------------------------------------------------------------------
    // a wrap in the same cycle as a software clear keeps the flag set
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            overflow_flag_q <= 1'b0;
        else if (wrap)
            overflow_flag_q <= 1'b1;
        else if (wr_flags)
            overflow_flag_q <= reg_wdata_i[GTC_BIT_OVERFLOW_FLAG];
    end

    // ------------------------------------------------------------------
    // interrupt request and wake
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            irq_o  <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            irq_o  <= overflow_flag_q && overflow_int_enable_q
                      && peripheral_int_enable_bit_q
                      && global_int_enable_q;
            // wake does not need the global enable, only vectoring does
            wake_o <= overflow_flag_q && overflow_int_enable_q
                      && peripheral_int_enable_bit_q && timer_on;
        end
    end

    // ------------------------------------------------------------------
    // shared pin view while the oscillator owns them
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            port_pin_view_o <= GTC_PORT_PIN_FORCED;
            port_dir_view_o <= GTC_PORT_DIR_FORCED;
            lp_osc_run_o    <= 1'b0;
        end
        else
        begin
            lp_osc_run_o    <= lp_osc_active;
            port_pin_view_o <= lp_osc_active ? GTC_PORT_PIN_FORCED
                                             : port_pin_i;
            port_dir_view_o <= lp_osc_active ? GTC_PORT_DIR_FORCED
                                             : port_dir_i;
        end
    end

    // ------------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------------
    // the count is a system-clock register, so a byte read can never
    // catch a half-updated value even from the unsynchronised source
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = GTC_RST_BYTE;
        unique case (reg_addr_i)
            GTC_ADDR_INTERRUPT_CONTROL:
            begin
                rd_mux[GTC_BIT_GLOBAL_INT_ENABLE]     = global_int_enable_q;
                rd_mux[GTC_BIT_PERIPH_INT_ENABLE_BIT] =
                    peripheral_int_enable_bit_q;
            end
            GTC_ADDR_PERIPHERAL_FLAGS:
                rd_mux[GTC_BIT_OVERFLOW_FLAG] = overflow_flag_q;
            GTC_ADDR_COUNT_LOW_BYTE:  rd_mux = count_q[7:0];
            GTC_ADDR_COUNT_HIGH_BYTE: rd_mux = count_q[15:8];
            GTC_ADDR_TIMER_CONTROL:   rd_mux = {1'b0, timer_control_q};
            GTC_ADDR_PERIPHERAL_INT_ENABLE:
                rd_mux[GTC_BIT_OVERFLOW_INT_ENABLE] = overflow_int_enable_q;
            default: rd_mux = GTC_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            reg_rdata_o <= GTC_RST_BYTE;
        else
            reg_rdata_o <= reg_rd_i ? rd_mux : GTC_RST_BYTE;
    end

endmodule

// ===== tb/gtc_clk_src_model.sv
// Purpose: external count clock source facing the timer pin
// Assumes: pulses are whole multiples of the system clock
// Notes:   the pin rests low between bursts; a burst opens with a rise
`timescale 1ns/1ps

module gtc_clk_src_model (
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic [7:0] pulses_i,
    input  wire logic [3:0] half_i,
    output logic            pin_o,
    output logic            busy_o
);
    logic [8:0] phase_q = 9'h000;
    logic [3:0] tick_q  = 4'h0;

    initial pin_o = 1'b0;
    assign busy_o = (phase_q != 9'h000);

    // two toggles per pulse, each after half_i system clocks
    always @(posedge clk_i)
    begin
        if (start_i)
        begin
            phase_q <= {pulses_i, 1'b0};
            tick_q  <= half_i;
        end
        else if (busy_o && tick_q == 4'h1)
        begin
            pin_o   <= ~pin_o;
            phase_q <= phase_q - 9'h001;
            tick_q  <= half_i;
        end
        else if (busy_o)
            tick_q <= tick_q - 4'h1;
    end
endmodule

// ===== tb/gtc_timer_sva.sv
// Purpose: port assertions for the gated 16-bit timer/counter
// Assumes: one clock, synchronous active-high reset
// Notes:   the flag is hidden, so irq and wake drops are tied to writes
`timescale 1ns/1ps

module gtc_timer_sva
    import gtc_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       srst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       internal_oscillator_i,
    input wire logic [1:0] port_pin_i,
    input wire logic [1:0] port_dir_i,
    input wire logic [1:0] port_pin_view_o,
    input wire logic [1:0] port_dir_view_o,
    input wire logic       lp_osc_run_o,
    input wire logic       irq_o,
    input wire logic       wake_o
);
    // ----
    // helpers
    // ----
    logic mapped;

    // the six implemented byte addresses
    assign mapped = reg_addr_i inside {GTC_ADDR_INTERRUPT_CONTROL,
        GTC_ADDR_PERIPHERAL_FLAGS, GTC_ADDR_COUNT_LOW_BYTE,
        GTC_ADDR_COUNT_HIGH_BYTE, GTC_ADDR_TIMER_CONTROL,
        GTC_ADDR_PERIPHERAL_INT_ENABLE};

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);

    // ----
    // register port
    // ----
    chk_rdata_quiet: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside the answer cycle");
    chk_unmapped_zero: assert property (
        reg_rd_i && !mapped |=> reg_rdata_o == 8'h00)
        else $error("unmapped address read nonzero");
    chk_ctrl_reserved: assert property (
        reg_rd_i && reg_addr_i == GTC_ADDR_TIMER_CONTROL
        |=> reg_rdata_o[7] == 1'b0)
        else $error("control bit 7 read as one");
    chk_flags_unused: assert property (
        reg_rd_i && reg_addr_i == GTC_ADDR_PERIPHERAL_FLAGS
        |=> reg_rdata_o[7:1] == 7'h00)
        else $error("unused flag bits nonzero");
    chk_enable_unused: assert property (
        reg_rd_i && reg_addr_i == GTC_ADDR_PERIPHERAL_INT_ENABLE
        |=> reg_rdata_o[7:1] == 7'h00)
        else $error("unused enable bits nonzero");
    chk_intctl_unused: assert property (
        reg_rd_i && reg_addr_i == GTC_ADDR_INTERRUPT_CONTROL
        |=> reg_rdata_o[5:0] == 6'h00)
        else $error("unused interrupt control bits nonzero");

    // ----
    // requests and shared pins
    // ----
    // hardware never drops the flag, so a drop needs a write two back
    chk_irq_hold: assert property (
        $fell(irq_o) |-> $past(reg_wr_i, 2))
        else $error("irq dropped without a register write");
    chk_wake_hold: assert property (
        $fell(wake_o) |-> $past(reg_wr_i, 2))
        else $error("wake dropped without a register write");
    chk_osc_pins: assert property (
        lp_osc_run_o |-> port_pin_view_o == GTC_PORT_PIN_FORCED
        && port_dir_view_o == GTC_PORT_DIR_FORCED)
        else $error("port views not forced while oscillator runs");
    chk_osc_needs_int: assert property (
        lp_osc_run_o |-> $past(internal_oscillator_i))
        else $error("oscillator runs without internal system clock");
    chk_pin_pass: assert property (
        !lp_osc_run_o && !$past(lp_osc_run_o) && !$past(srst_i)
        |-> port_pin_view_o == $past(port_pin_i)
        && port_dir_view_o == $past(port_dir_i))
        else $error("port views do not follow the pins");
endmodule

bind gtc_timer gtc_timer_sva chk (
    .clk_sys_i, .srst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .internal_oscillator_i, .port_pin_i, .port_dir_i,
    .port_pin_view_o, .port_dir_view_o, .lp_osc_run_o, .irq_o, .wake_o
);

// ===== tb/tb_gtc_timer.sv
// Purpose: register-level test of the gated 16-bit timer/counter
// Assumes: timer runs last a whole number of instruction cycles
// Notes:   the low-power oscillator input rests low to expose source muxing
`timescale 1ns/1ps

module tb_gtc_timer
    import gtc_pkg::*;
    ;
    logic       clk_sys_i = 1'b0;
    logic       srst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic       ext_pin, src_busy, irq_o, wake_o, lp_osc_run_o;
    logic       src_start = 1'b0;
    logic [7:0] src_n = 8'h00;
    logic       lp_osc_clk_i = 1'b0;
    logic       gate_pin_n_i = 1'b1;
    logic       sleep_i = 1'b0;
    logic       int_osc = 1'b0;
    logic [1:0] port_pin_i = 2'h2;
    logic [1:0] port_dir_i = 2'h1;
    logic [1:0] pin_view, dir_view;
    int         error_cnt = 0;
    int         n_compared = 0;
    int         cyc = 0;

    gtc_timer uut (.clk_sys_i, .srst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .ext_clock_pin_i(ext_pin),
        .lp_osc_clk_i, .gate_pin_n_i, .sleep_i,
        .internal_oscillator_i(int_osc), .port_pin_i, .port_dir_i,
        .port_pin_view_o(pin_view), .port_dir_view_o(dir_view),
        .lp_osc_run_o, .irq_o, .wake_o);
    gtc_clk_src_model src (.clk_i(clk_sys_i), .start_i(src_start),
        .pulses_i(src_n), .half_i(4'h4), .pin_o(ext_pin),
        .busy_o(src_busy));

    always #5 clk_sys_i = ~clk_sys_i;

    // ----
    // shared tasks
    // ----
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i    <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i   <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        check(d, e);
    endtask

    // count is loaded only while stopped, to avoid write contention
    task automatic set_cnt(input logic [15:0] v);
        wr(GTC_ADDR_COUNT_LOW_BYTE, v[7:0]);
        wr(GTC_ADDR_COUNT_HIGH_BYTE, v[15:8]);
    endtask

    // one counting run: n cycles, or n source pulses when external
    task automatic run_chk(input logic [7:0] ctrl, input logic slp,
        input logic io, input logic g, input int n, input logic [7:0] e);
        logic [7:0] d;
        @(posedge clk_sys_i);
        sleep_i      <= slp;
        int_osc      <= io;
        gate_pin_n_i <= g;
        port_pin_i   <= ctrl[5:4];
        port_dir_i   <= ~ctrl[5:4];
        set_cnt(16'h0000);
        wr(GTC_ADDR_TIMER_CONTROL, ctrl);
        if (ctrl[1])
        begin
            @(posedge clk_sys_i);
            src_n     <= n[7:0];
            src_start <= 1'b1;
            @(posedge clk_sys_i);
            src_start <= 1'b0;
            @(posedge clk_sys_i);
            while (src_busy !== 1'b0)
                @(posedge clk_sys_i);
        end
        else
            repeat (n - 2) @(posedge clk_sys_i);
        wr(GTC_ADDR_TIMER_CONTROL, 8'h00);
        rd(GTC_ADDR_COUNT_LOW_BYTE, d);
        check(d, e);
    endtask

    // hang guard
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            complete_run();
        end
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        logic [7:0] d;
        repeat (4) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rd_chk(GTC_ADDR_INTERRUPT_CONTROL, 8'h00);
        rd_chk(GTC_ADDR_PERIPHERAL_FLAGS, 8'h00);
        rd_chk(GTC_ADDR_PERIPHERAL_INT_ENABLE, 8'h00);
        rd_chk(GTC_ADDR_TIMER_CONTROL, 8'h00);
        wr(8'h0d, 8'hff);
        rd_chk(8'h0d, 8'h00);
        wr(GTC_ADDR_TIMER_CONTROL, 8'hb4);
        rd_chk(GTC_ADDR_TIMER_CONTROL, 8'h34);
        for (int ps = 0; ps < 4; ps++)
            run_chk(8'(8'h01 | (ps << 4)), 0, 0, 1,
                40 << ps, 8'd10);
        run_chk(8'h41, 0, 0, 1, 40, 8'h00);
        run_chk(8'h41, 0, 0, 0, 40, 8'd10);
        run_chk(8'h40, 0, 0, 0, 40, 8'h00);
        run_chk(8'h05, 0, 0, 1, 40, 8'd10);
        // leaves the prescaler at one; the next load must clear it
        run_chk(8'h31, 0, 0, 1, 36, 8'h01);
        run_chk(8'h31, 0, 0, 1, 28, 8'h00);
        run_chk(8'h03, 0, 0, 1, 5, 8'd4);
        run_chk(8'h07, 1, 0, 1, 5, 8'd4);
        run_chk(8'h03, 1, 0, 1, 5, 8'h00);
        run_chk(8'h01, 1, 0, 1, 40, 8'h00);
        run_chk(8'h0b, 0, 1, 1, 5, 8'h00);
        run_chk(8'h0b, 0, 0, 1, 5, 8'd4);
        @(posedge clk_sys_i);
        sleep_i <= 1'b0;
        int_osc <= 1'b1;
        wr(GTC_ADDR_TIMER_CONTROL, 8'h08);
        rd_chk(GTC_ADDR_TIMER_CONTROL, 8'h08);
        check({lp_osc_run_o, pin_view, dir_view, 3'h0}, 8'h98);
        // overflow through all-ones; flag cleared before the enables
        set_cnt(16'hfffe);
        wr(GTC_ADDR_PERIPHERAL_FLAGS, 8'h00);
        wr(GTC_ADDR_PERIPHERAL_INT_ENABLE, 8'h01);
        wr(GTC_ADDR_INTERRUPT_CONTROL, 8'hc0);
        wr(GTC_ADDR_TIMER_CONTROL, 8'h01);
        repeat (20) @(posedge clk_sys_i);
        #1 check({6'h00, irq_o, wake_o}, 8'h03);
        wr(GTC_ADDR_TIMER_CONTROL, 8'h00);
        rd(GTC_ADDR_COUNT_HIGH_BYTE, d);
        check(d, 8'h00);
        rd_chk(GTC_ADDR_PERIPHERAL_FLAGS, 8'h01);
        check({6'h00, irq_o, wake_o}, 8'h02);
        wr(GTC_ADDR_INTERRUPT_CONTROL, 8'h40);
        rd_chk(GTC_ADDR_PERIPHERAL_FLAGS, 8'h01);
        check({6'h00, irq_o, wake_o}, 8'h00);
        wr(GTC_ADDR_PERIPHERAL_FLAGS, 8'h00);
        rd_chk(GTC_ADDR_PERIPHERAL_FLAGS, 8'h00);
        complete_run();
    end
endmodule
